//--- hdl/pmc_pkg.sv
// constants and types for the power mode controller
package pmc_pkg;
  localparam logic [31:0] ctl_one_addr = 32'h0000_0000;
  localparam logic [31:0] ctl_two_addr = 32'h0000_0004;
  localparam logic [31:0] option_addr = 32'h0000_0008;
  localparam logic [31:0] status_addr = 32'h0000_000c;
  localparam int one_sleep_bit = 0;
  localparam int one_halt_bit = 1;
  localparam int two_arm_bit = 0;
  localparam int opt_wake_bit = 0;
  localparam int opt_sel_one_lsb = 4;
  localparam int opt_sel_two_lsb = 8;
  localparam int opt_pull_lsb = 12;
  localparam logic [15:0] option_reset = 16'h0000;
  localparam int wake_min_ns = 10000;
  localparam int clk_period_ns = 10;
  localparam int wake_min_cycles =
    (wake_min_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int cpu_reset_delay = 32768;
  typedef enum logic [2:0] {
    pmc_active, pmc_standby, pmc_sleep, pmc_startup, pmc_reset
  } pmc_mode_type;
endpackage : pmc_pkg

//--- hdl/pmc_power_mode_control.sv
// power mode controller: active, standby and sleep sequencing
`timescale 1ns/100ps
module pmc_power_mode_control #(
  parameter int startup_cycles = pmc_pkg::cpu_reset_delay,
  parameter int wake_cycles = pmc_pkg::wake_min_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic irq_pending,
  input wire logic reset_pin,
  input wire logic [3:0] input_port_a,
  input wire logic port_reset_active,
  input wire logic level_measure_busy,
  output logic instr_clk_en,
  output logic osc_en,
  output logic cpu_reset,
  output logic system_reset,
  output logic periph_run,
  output logic port_b_hiz,
  output logic port_a_en,
  output logic level_detect_en,
  output logic strobe_sleep,
  output logic [3:0] pull_sel
);
  import pmc_pkg::*;

  pmc_mode_type mode_r, mode_nxt;
  logic sleep_r, sleep_nxt;
  logic arm_r;
  logic [15:0] option_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic [31:0] prdata_r;

  wire logic wr_en = psel && penable && pwrite;
  wire logic rd_en = psel && penable && !pwrite;
  wire logic hit_one = paddr == ctl_one_addr;
  wire logic hit_two = paddr == ctl_two_addr;
  wire logic hit_opt = paddr == option_addr;
  wire logic hit_stat = paddr == status_addr;
  wire logic mapped = hit_one || hit_two || hit_opt || hit_stat;
  wire logic wake_opt = option_r[opt_wake_bit];
  wire logic [3:0] sel_one = option_r[opt_sel_one_lsb +: 4];
  wire logic [3:0] sel_two = option_r[opt_sel_two_lsb +: 4];

  // selected port a combination: terms anded, a bit with both selects set is skipped and one with neither forces 0
  function automatic logic port_combo(input logic [3:0] s1,
                                      input logic [3:0] s2,
                                      input logic [3:0] pa);
    logic r;
    r = 1'b1;
    for (int n = 0; n < 4; n++) begin
      unique case ({s1[n], s2[n]})
        2'b00: r = 1'b0;
        2'b01: r = r & pa[n];
        2'b10: r = r & ~pa[n];
        2'b11: r = r;
      endcase
    end
    return r;
  endfunction : port_combo

  wire logic combo_hit = port_combo(sel_one, sel_two, input_port_a);
  wire logic sleep_wr = wr_en && hit_one && pwdata[one_sleep_bit];
  wire logic sleep_go = sleep_wr && arm_r;
  wire logic halt_go = halt_exec ||
    (wr_en && hit_one && pwdata[one_halt_bit]);
  wire logic pin_long = reset_pin && cnt_r >= 16'(wake_cycles - 1);
  wire logic wake_go = pin_long || (wake_opt && combo_hit);
  wire logic start_done = cnt_r >= 16'(startup_cycles - 1);

  always_comb begin
    mode_nxt = mode_r;
    sleep_nxt = sleep_r;
    cnt_nxt = cnt_r;
    unique case (mode_r)
      pmc_active: begin
        // only three exits from active
        if (port_reset_active) begin
          mode_nxt = pmc_reset;
        end else if (sleep_go) begin
          mode_nxt = pmc_sleep;
          sleep_nxt = 1'b1;
          cnt_nxt = 16'h0000;
        end else if (halt_go) begin
          mode_nxt = pmc_standby;
        end
      end
      pmc_standby: begin
        if (port_reset_active) begin
          mode_nxt = pmc_reset;
        end else if (irq_pending) begin
          mode_nxt = pmc_active;
        end
      end
      pmc_sleep: begin
        cnt_nxt = reset_pin ? cnt_r + 16'h0001 : 16'h0000;
        if (wake_go) begin
          mode_nxt = pmc_startup;
          sleep_nxt = 1'b0;
          cnt_nxt = 16'h0000;
        end
      end
      pmc_startup: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (start_done) begin
          mode_nxt = pmc_active;
        end
      end
      pmc_reset: begin
        if (!port_reset_active) begin
          mode_nxt = pmc_active;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= pmc_active;
      sleep_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else begin
      mode_r <= mode_nxt;
      sleep_r <= sleep_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // arm and options survive system resets
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      arm_r <= 1'b0;
      option_r <= option_reset;
    end else begin
      if (wr_en && hit_two) begin
        arm_r <= pwdata[two_arm_bit];
      end
      if (wr_en && hit_opt && mode_r == pmc_active) begin
        option_r <= pwdata[15:0];
      end
    end
  end

  wire logic in_sleep = mode_r == pmc_sleep;
  wire logic in_hold = in_sleep || mode_r == pmc_startup ||
    mode_r == pmc_reset;
  wire logic [31:0] rd_mux =
    hit_one ? {31'h0, sleep_r} :
    hit_two ? {31'h0, arm_r} :
    hit_opt ? {16'h0, option_r} :
    hit_stat ? {29'h0, mode_r} : 32'h0000_0000;

  // read data loaded in setup so it stands through the access edge
  wire logic setup_ph = psel && !penable;
  wire logic [31:0] prdata_nxt = setup_ph ? rd_mux : prdata_r;
  wire logic pslverr_nxt = setup_ph && !mapped;
  // instruction clock stops in standby; level detect stays on only while a measure is busy
  wire logic instr_clk_en_nxt = mode_nxt == pmc_active;
  wire logic osc_en_nxt = mode_nxt != pmc_sleep;
  wire logic cpu_reset_nxt = mode_nxt inside {pmc_sleep, pmc_startup,
    pmc_reset};
  wire logic system_reset_nxt = mode_nxt inside {pmc_sleep,
    pmc_reset};
  wire logic periph_run_nxt = !(mode_nxt inside {pmc_sleep,
    pmc_startup});
  wire logic port_b_hiz_nxt = mode_nxt == pmc_sleep;
  wire logic port_a_en_nxt = mode_nxt != pmc_sleep || wake_opt;
  wire logic level_detect_en_nxt = (mode_nxt == pmc_active) ||
    (mode_nxt == pmc_standby && level_measure_busy) ||
    (mode_r == pmc_active && level_measure_busy);
  wire logic strobe_sleep_nxt = sleep_nxt;
  wire logic [3:0] pull_sel_nxt = option_r[opt_pull_lsb +: 4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_nxt;
    end
  end

  // no wait states: ready once out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_clk_en <= 1'b1;
    end else begin
      instr_clk_en <= instr_clk_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en <= 1'b1;
    end else begin
      osc_en <= osc_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset <= 1'b0;
    end else begin
      cpu_reset <= cpu_reset_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset <= 1'b0;
    end else begin
      system_reset <= system_reset_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_run <= 1'b1;
    end else begin
      periph_run <= periph_run_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_hiz <= 1'b0;
    end else begin
      port_b_hiz <= port_b_hiz_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_en <= 1'b1;
    end else begin
      port_a_en <= port_a_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_detect_en <= 1'b1;
    end else begin
      level_detect_en <= level_detect_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_sleep <= 1'b0;
    end else begin
      strobe_sleep <= strobe_sleep_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_sel <= 4'h0;
    end else begin
      pull_sel <= pull_sel_nxt;
    end
  end

  assign prdata = prdata_r;
  wire logic unused_ok = in_hold;
endmodule : pmc_power_mode_control

//--- test/pmc_chk.sv
// assertions on the power mode controller outputs
`timescale 1ns/100ps
module pmc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin,
  input wire logic irq_pending,
  input wire logic level_measure_busy,
  input wire logic instr_clk_en,
  input wire logic osc_en,
  input wire logic cpu_reset,
  input wire logic system_reset,
  input wire logic periph_run,
  input wire logic port_b_hiz,
  input wire logic port_a_en,
  input wire logic level_detect_en,
  input wire logic strobe_sleep
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire stby = !instr_clk_en && osc_en && !cpu_reset;
  sleep_pins_a: assert property (strobe_sleep |-> port_b_hiz)
    else $error("port b driven in sleep");
  sleep_osc_a: assert property (strobe_sleep |-> !osc_en)
    else $error("oscillator on in sleep");
  sleep_rst_a: assert property (!osc_en |-> cpu_reset)
    else $error("cpu not in reset while oscillator off");
  standby_run_a: assert property (stby |-> periph_run && !system_reset)
    else $error("standby stopped peripherals");
  level_fin_a: assert property ($fell(level_detect_en) && osc_en
    |-> !$past(level_measure_busy)) else $error("measure cut short");
  irq_wake_a: assert property (stby && irq_pending |-> ##[1:3] instr_clk_en)
    else $error("no wake on interrupt");
  wake_cause_a: assert property ($fell(strobe_sleep) |->
    $past(reset_pin) || $past(reset_pin, 2) || $past(port_a_en))
    else $error("sleep left without wake cause");
  startup_hold_a: assert property ($rose(osc_en) |-> cpu_reset[*8])
    else $error("cpu reset released early");
endmodule : pmc_chk
bind pmc_power_mode_control pmc_chk chk_i (.*);

//--- test/pmc_wake_src.sv
// reset pin and port a wake source model
`timescale 1ns/100ps
module pmc_wake_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] len,
  output logic reset_pin,
  output logic [3:0] input_port_a
);
  logic [7:0] cnt_r = 8'h00;
  always_ff @(posedge pclk) begin
    cnt_r <= go ? len : cnt_r - {7'h00, cnt_r != 8'h00};
  end
  assign reset_pin = cnt_r != 8'h00;
  // port a held at 4'h5 on this bench
  assign input_port_a = 4'h5;
endmodule : pmc_wake_src

//--- test/tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
module tb_top;
  import pmc_pkg::*;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0;
  logic pwrite = 0, halt_exec = 0, irq_pending = 0, go = 0, err;
  logic port_reset_active = 0, level_measure_busy = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, instr_clk_en, osc_en, cpu_reset, system_reset;
  logic periph_run, port_b_hiz, port_a_en, level_detect_en, strobe_sleep;
  logic reset_pin;
  logic [3:0] input_port_a, pull_sel;
  logic [7:0] len = 0;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  pmc_wake_src src (.*);
  pmc_power_mode_control #(.startup_cycles(8), .wake_cycles(4)) uut (.*);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string nm);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic t_reset();
    apb(0, ctl_two_addr, 0);
    chk(rd[two_arm_bit], 0, "arm after power up");
    apb(1, ctl_one_addr, 1);
    apb(0, status_addr, 0);
    chk(rd, 0, "unarmed sleep write");
    apb(0, 32'h10, 0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task automatic t_halt();
    level_measure_busy <= 1;
    halt_exec <= 1;
    @(posedge pclk) halt_exec <= 0;
    repeat (3) @(posedge pclk);
    chk({instr_clk_en, osc_en, periph_run, level_detect_en}, 4'h7, "stby");
    level_measure_busy <= 0;
    apb(0, status_addr, 0);
    chk({rd, level_detect_en}, {32'h1, 1'b0}, "standby mode");
    irq_pending <= 1;
    repeat (3) @(posedge pclk);
    chk(instr_clk_en, 1, "irq wake");
    irq_pending <= 0;
    port_reset_active <= 1;
    @(posedge pclk);
    apb(0, status_addr, 0);
    chk(rd, 4, "port reset mode");
    port_reset_active <= 0;
    $display("test halt done");
  endtask : t_halt
  task automatic t_sleep();
    apb(1, ctl_two_addr, 1);
    apb(1, ctl_one_addr, 1);
    repeat (2) @(posedge pclk);
    chk({osc_en, port_b_hiz, cpu_reset, port_a_en}, 4'h6, "sleep pins");
    len <= 2;
    go <= 1;
    @(posedge pclk) go <= 0;
    repeat (6) @(posedge pclk);
    chk(strobe_sleep, 1, "short pulse");
    len <= 6;
    go <= 1;
    @(posedge pclk) go <= 0;
    for (int i = 0; i < 40 && cpu_reset !== 1'b0; i++) @(posedge pclk);
    apb(0, ctl_one_addr, 0);
    chk(rd[one_sleep_bit], 0, "sleep flag");
    apb(0, ctl_two_addr, 0);
    chk(rd[two_arm_bit], 1, "arm after wake");
    apb(1, option_addr, 32'h0000_35a1);
    @(posedge pclk);
    chk(pull_sel, 4'h3, "pull select");
    apb(1, ctl_one_addr, 1);
    chk(port_a_en, 1, "port a kept in sleep");
    for (int i = 0; i < 40 && cpu_reset !== 1'b0; i++) @(posedge pclk);
    apb(0, ctl_one_addr, 0);
    chk(rd[one_sleep_bit], 0, "port wake");
    $display("test sleep done");
  endtask : t_sleep
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    @(posedge pclk);
    t_reset();
    t_halt();
    t_sleep();
    end_sim();
  end
endmodule : tb_top
